// ---- rtl/faa_defines.vh ----
// Purpose: shared constants of the float magnitude/add unit
// Assumes: 32-bit single-precision operands, AXI4-Lite register window of 12 address bits
// Notes: definitions only
`ifndef FAA_DEFINES_VH
`define FAA_DEFINES_VH

// ==================================================================
// operation codes
`define FAA_OP_ABS 2'h0
`define FAA_OP_ABS_FLAGS 2'h1
`define FAA_OP_ADD 2'h2
`define FAA_OP_ADD_FLAGS 2'h3

// ==================================================================
// exception flag positions, status word and reported vector alike
`define FAA_F_DIV_ZERO 0
`define FAA_F_INEXACT 1
`define FAA_F_UNDER 2
`define FAA_F_OVER 3
`define FAA_F_BAD_OP 4
`define FAA_F_IN_FLUSH 5
`define FAA_F_OUT_FLUSH 6
`define FAA_NFLAGS 7

// ==================================================================
// rounding modes, held in the status word
`define FAA_RM_NEAREST 2'h0
`define FAA_RM_ZERO 2'h1
`define FAA_RM_UP 2'h2
`define FAA_RM_DOWN 2'h3
`define FAA_SW_RM_LSB 8

// ==================================================================
// register byte offsets
`define FAA_REG_STATUS_WORD 12'h000
`define FAA_REG_IRQ_STATUS 12'h004
`define FAA_REG_IRQ_MASK 12'h008

// ==================================================================
// reset values and special encodings
`define FAA_RST_FLAGS 7'h00
`define FAA_RST_RM 2'h0
`define FAA_RST_MASK 7'h00
`define FAA_QNAN 32'hffffffff
`define FAA_RESP_OKAY 2'h0
`define FAA_RESP_SLVERR 2'h2

`endif

// ---- rtl/faa_float_abs_add_unit.v ----
// Purpose: single-precision magnitude and add, their flag-reporting variants,
//          sticky exception flags of the processor status word, guarded write-back
// Assumes: one operation issued per cycle at most; fixed three-stage pipeline
// Notes: status word, interrupt status and mask reached over AXI4-Lite
// Behaviour
// RL1: magnitude returns absolute value of its single-precision operand.
// RL2: magnitude replaces a denormal operand by zero and sets input-flush flag.
// RL3: add returns single-precision sum of both operands to the destination.
// RL4: add rounds by the rounding mode held in the status word.
// RL5: add replaces each denormal operand by zero and sets input-flush flag.
// RL6: a denormal add result becomes zero and sets output-flush flag.
// RL7: exceptions raised by add set matching status word flags.
// RL8: status flags are sticky; only an explicit status word write clears them.
// RL9: flag update happens in the same cycle as the destination write.
// RL10: simultaneous updates are ORed together with the existing flag value.
// RL11: false guard suppresses destination write and flag change for base operations.
// RL12: with a guard given, destination written only when guard bit 0 is one.
// RL13: flag variants write the would-be flags as integer, status word untouched.
// RL14: reported vector bits 0..6 hold the seven flags, bits 7..31 zero.
// RL15: magnitude flag variant sets input-flush bit for a denormal operand.
// RL16: add flag variant sets output-flush bit when the sum would be denormal.
// RL17: quiet NaN passes through magnitude unchanged with no flag raised.
// RL18: signalling NaN into magnitude gives quiet NaN and raises invalid.
// RL19: adding opposite infinities gives quiet NaN and raises invalid.
`timescale 1ns/1ps
`default_nettype none
`include "faa_defines.vh"

module faa_float_abs_add_unit (
   input wire clk,
   input wire rst,
   input wire op_valid,
   input wire [1:0] op_code,
   input wire [31:0] first_source,
   input wire [31:0] second_source,
   input wire guard_used,
   input wire [31:0] guard,
   input wire [6:0] op_dest,
   input wire other_update_valid,
   input wire [6:0] other_update_flags,
   output reg result_write,
   output reg [6:0] result_dest,
   output reg [31:0] result_data,
   output wire [6:0] status_flags,
   output wire [1:0] round_mode,
   output wire irq,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ==================================================================
   // pipeline stage 1: captured issue
   reg s1_valid;
   reg [1:0] s1_op;
   reg [31:0] s1_a;
   reg [31:0] s1_b;
   reg [6:0] s1_dest;
   reg [1:0] s1_rm;
   // stage 2: computed result
   reg s2_valid;
   reg s2_upd;
   reg [6:0] s2_dest;
   reg [31:0] s2_data;
   reg [6:0] s2_flags;
   // stage 3 flag part travels with result_write
   reg s3_upd;
   reg [6:0] s3_flags;
   reg [6:0] flags;
   reg [1:0] rm;
   reg [6:0] irq_status;
   reg [6:0] irq_mask;

   // only bit 0 of the guard counts; upper bits are don't-care
   wire guard_ok = ~guard_used | guard[0]; // [RL12]

   // ==================================================================
   // magnitude
   reg [31:0] abs_res;
   reg [6:0] abs_fl;
   always @* begin
      abs_fl = 7'h00;
      abs_res = {1'b0, s1_a[30:0]}; // [RL1]
      if (s1_a[30:23] == 8'h00) begin
         abs_res = 32'h00000000;
         abs_fl[`FAA_F_IN_FLUSH] = (s1_a[22:0] != 23'h0); // [RL2] [RL15]
      end else if (s1_a[30:23] == 8'hff && s1_a[22:0] != 23'h0) begin
         if (s1_a[22]) begin
            abs_res = s1_a; // [RL17]
         end else begin
            abs_res = `FAA_QNAN; // [RL18]
            abs_fl[`FAA_F_BAD_OP] = 1'b1; // [RL18]
         end
      end
   end

   // ==================================================================
   // add: flush denormal inputs, align, sum, normalise, round
   reg [31:0] add_res;
   reg [6:0] add_fl;
   reg sa, sb, sx, sub, nan_a, nan_b, inf_a, inf_b, infinf;
   reg [23:0] ma, mb, mx, my;
   reg [7:0] ex, ey, d;
   reg [50:0] big;
   reg [26:0] al;
   reg [27:0] sum;
   reg [26:0] nm;
   reg [4:0] sh;
   reg [9:0] e;
   reg [9:0] e2;
   reg [24:0] mr;
   reg inc, lost_bits;
   integer i;
   always @* begin
      add_fl = 7'h00;
      sa = s1_a[31];
      sb = s1_b[31];
      nan_a = (s1_a[30:23] == 8'hff) && (s1_a[22:0] != 23'h0);
      nan_b = (s1_b[30:23] == 8'hff) && (s1_b[22:0] != 23'h0);
      inf_a = (s1_a[30:23] == 8'hff) && (s1_a[22:0] == 23'h0);
      inf_b = (s1_b[30:23] == 8'hff) && (s1_b[22:0] == 23'h0);
      infinf = inf_a & inf_b & (sa ^ sb);
      // exponent zero counts as zero, denormal or not
      ma = (s1_a[30:23] == 8'h00) ? 24'h000000 : {1'b1, s1_a[22:0]}; // [RL5]
      mb = (s1_b[30:23] == 8'h00) ? 24'h000000 : {1'b1, s1_b[22:0]}; // [RL5]
      add_fl[`FAA_F_IN_FLUSH] = (s1_a[30:23] == 8'h00 && s1_a[22:0] != 23'h0) ||
                           (s1_b[30:23] == 8'h00 && s1_b[22:0] != 23'h0); // [RL5]
      if ({s1_b[30:23], mb} > {s1_a[30:23], ma}) begin
         sx = sb;
         ex = s1_b[30:23];
         mx = mb;
         ey = s1_a[30:23];
         my = ma;
      end else begin
         sx = sa;
         ex = s1_a[30:23];
         mx = ma;
         ey = s1_b[30:23];
         my = mb;
      end
      sub = sa ^ sb;
      d = ex - ey;
      // shift capped at 28: everything beyond lands in sticky anyway
      big = {my, 27'h0000000} >> ((d > 8'd27) ? 5'd28 : d[4:0]);
      al = {big[50:25], big[24] | (|big[23:0])};
      if (sub)
         sum = {1'b0, mx, 3'b000} - {1'b0, al};
      else
         sum = {1'b0, mx, 3'b000} + {1'b0, al};
      e = {2'b00, ex};
      sh = 5'd0;
      if (sum[27]) begin
         nm = {sum[27:2], sum[1] | sum[0]};
         e = e + 10'd1;
      end else begin
         for (i = 0; i < 27; i = i + 1)
            if (sum[i])
               sh = 5'd26 - i[4:0];
         nm = sum[26:0] << sh;
         e = e - {5'b00000, sh};
      end
      // rounding per status word mode
      // guard, round and sticky bits sit in nm[2:0]
      lost_bits = nm[2] | nm[1] | nm[0];
      case (s1_rm)
         `FAA_RM_NEAREST: inc = nm[2] & (nm[1] | nm[0] | nm[3]);
         `FAA_RM_ZERO: inc = 1'b0;
         `FAA_RM_UP: inc = lost_bits & ~sx;
         `FAA_RM_DOWN: inc = lost_bits & sx;
         default: inc = 1'b0;
      endcase // [RL4]
      mr = {1'b0, nm[26:3]} + {24'h000000, inc};
      e2 = e + {9'h000, mr[24]};
      add_res = {sx, e2[7:0], mr[24] ? mr[23:1] : mr[22:0]}; // [RL3]
      add_fl[`FAA_F_INEXACT] = lost_bits; // [RL7]
      if (nan_a | nan_b | infinf) begin
         add_res = `FAA_QNAN; // [RL19]
         add_fl[`FAA_F_INEXACT] = 1'b0;
         add_fl[`FAA_F_BAD_OP] = infinf | (nan_a & ~s1_a[22]) | (nan_b & ~s1_b[22]); // [RL19] [RL7]
      end else if (inf_a) begin
         add_res = s1_a;
         add_fl[`FAA_F_INEXACT] = 1'b0;
      end else if (inf_b) begin
         add_res = s1_b;
         add_fl[`FAA_F_INEXACT] = 1'b0;
      end else if (sum == 28'h0000000) begin
         // exact zero: negative only when both signs agree negative or rounding down
         add_res = {sub ? (s1_rm == `FAA_RM_DOWN) : sa, 31'h00000000};
         add_fl[`FAA_F_INEXACT] = 1'b0;
      end else if (e[9] || e == 10'd0) begin
         // would be denormal: flushed, reported as underflow and inexact
         add_res = {sx, 31'h00000000}; // [RL6]
         add_fl[`FAA_F_OUT_FLUSH] = 1'b1; // [RL6] [RL16]
         add_fl[`FAA_F_UNDER] = 1'b1; // [RL7]
         add_fl[`FAA_F_INEXACT] = 1'b1; // [RL7]
      end else if (e2 >= 10'd255) begin
         add_fl[`FAA_F_OVER] = 1'b1; // [RL7]
         add_fl[`FAA_F_INEXACT] = 1'b1;
         // modes rounding toward zero saturate at the largest finite value
         if (s1_rm == `FAA_RM_ZERO || (s1_rm == `FAA_RM_UP && sx) || (s1_rm == `FAA_RM_DOWN && ~sx))
            add_res = {sx, 31'h7f7fffff};
         else
            add_res = {sx, 31'h7f800000};
      end
   end

   // ==================================================================
   // stage selection of result and flag vector
   // flag variants carry the vector as data and never reach the status word
   reg [31:0] next_data;
   reg [6:0] next_fl;
   reg next_upd;
   always @* begin
      next_fl = (s1_op[1]) ? add_fl : abs_fl;
      next_upd = ~s1_op[0];
      if (s1_op[0])
         next_data = {25'h0000000, next_fl}; // [RL13] [RL14]
      else
         next_data = s1_op[1] ? add_res : abs_res;
   end

   always @(posedge clk) begin
      if (rst) begin
         s1_valid <= 1'b0;
         s1_op <= `FAA_OP_ABS;
         s1_a <= 32'h00000000;
         s1_b <= 32'h00000000;
         s1_dest <= 7'h00;
         s1_rm <= `FAA_RST_RM;
         s2_valid <= 1'b0;
         s2_upd <= 1'b0;
         s2_dest <= 7'h00;
         s2_data <= 32'h00000000;
         s2_flags <= 7'h00;
         result_write <= 1'b0;
         result_dest <= 7'h00;
         result_data <= 32'h00000000;
         s3_upd <= 1'b0;
         s3_flags <= 7'h00;
      end else begin
         // a false guard drops the op here, so neither write nor flags follow
         s1_valid <= op_valid & guard_ok; // [RL11] [RL12]
         s1_op <= op_code;
         s1_a <= first_source;
         s1_b <= second_source;
         s1_dest <= op_dest;
         s1_rm <= rm; // [RL4]
         s2_valid <= s1_valid;
         s2_upd <= s1_valid & next_upd; // [RL13]
         s2_dest <= s1_dest;
         s2_data <= next_data;
         s2_flags <= next_fl;
         result_write <= s2_valid;
         result_dest <= s2_dest;
         result_data <= s2_data;
         s3_upd <= s2_upd;
         s3_flags <= s2_flags;
      end
   end

   // ==================================================================
   // AXI4-Lite slave
   reg aw_full;
   reg w_full;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   // both slots refuse while a response waits: one write in flight at most
   assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire do_wr = aw_full & w_full & ~s_axi_bvalid;
   wire wr_sw = do_wr && aw_addr == `FAA_REG_STATUS_WORD;
   wire wr_is = do_wr && aw_addr == `FAA_REG_IRQ_STATUS;
   wire wr_mk = do_wr && aw_addr == `FAA_REG_IRQ_MASK;
   wire wr_ok = wr_sw | wr_is | wr_mk;

   always @(posedge clk) begin
      if (rst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FAA_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `FAA_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
         end else if (do_wr) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_wr) begin
            w_full <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `FAA_RESP_OKAY : `FAA_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FAA_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
               `FAA_REG_STATUS_WORD: s_axi_rdata <= {22'h000000, rm, 1'b0, flags};
               `FAA_REG_IRQ_STATUS: s_axi_rdata <= {25'h0000000, irq_status};
               `FAA_REG_IRQ_MASK: s_axi_rdata <= {25'h0000000, irq_mask};
               // unmapped: zero data with an error response
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `FAA_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==================================================================
   // status word flags and interrupt
   // the flag update takes base ops whose write lands this cycle, ORed with any other update
   wire [6:0] upd = ((result_write & s3_upd) ? s3_flags : 7'h00) | // [RL9] [RL11]
                    (other_update_valid ? other_update_flags : 7'h00); // [RL10]
   // a set arriving with the clearing write still wins
   wire [6:0] next_flags = ((wr_sw & w_strb[0]) ? w_data[6:0] : flags) | upd; // [RL8] [RL10]
   wire [6:0] next_irq_status = (irq_status & ~((wr_is & w_strb[0]) ? w_data[6:0] : 7'h00)) | upd;

   always @(posedge clk) begin
      if (rst) begin
         flags <= `FAA_RST_FLAGS;
         rm <= `FAA_RST_RM;
         irq_status <= 7'h00;
         irq_mask <= `FAA_RST_MASK;
      end else begin
         flags <= next_flags; // [RL7] [RL8]
         if (wr_sw & w_strb[1])
            rm <= w_data[`FAA_SW_RM_LSB+1:`FAA_SW_RM_LSB];
         irq_status <= next_irq_status;
         if (wr_mk & w_strb[0])
            irq_mask <= w_data[6:0];
      end
   end

   assign status_flags = flags;
   assign round_mode = rm;
   assign irq = |(irq_status & irq_mask);

endmodule // faa_float_abs_add_unit

`default_nettype wire

// ---- tb/faa_checker_sva.sv ----
// Purpose: port assertions for the float magnitude/add unit
// Assumes: fixed three-cycle issue-to-write latency
// Notes: bound onto every instance of the unit
`timescale 1ns/1ps
`default_nettype none

module faa_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire logic [1:0] op_code,
   input wire logic guard_used,
   input wire logic [31:0] guard,
   input wire logic other_update_valid,
   input wire logic [6:0] other_update_flags,
   input wire logic result_write,
   input wire logic [31:0] result_data,
   input wire logic [6:0] status_flags,
   input wire logic s_axi_bvalid
);
   logic go;
   assign go = op_valid && (!guard_used || guard[0]);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ==========
   // assertions
   chk_issue_latency: assert property (go |-> ##3 result_write)
      else $error("no write three cycles after issue");
   chk_guard_drop: assert property (op_valid && guard_used && !guard[0] |-> ##3 !result_write)
      else $error("false-guarded op wrote back");
   chk_write_cause: assert property (result_write |-> $past(go, 3))
      else $error("write with no accepted issue");
   // a register write is the only way flags may drop
   chk_flags_sticky: assert property (!$past(rst) && !$rose(s_axi_bvalid)
      |-> ($past(status_flags) & ~status_flags) == 7'h00)
      else $error("status flag cleared without write");
   chk_other_or: assert property (other_update_valid
      |=> (status_flags & $past(other_update_flags)) == $past(other_update_flags))
      else $error("simultaneous update lost");
   chk_flag_timing: assert property (!$past(rst) && status_flags != $past(status_flags)
      && !$past(other_update_valid) && !$rose(s_axi_bvalid) |-> $past(result_write))
      else $error("flags moved apart from write-back");
   chk_vector_upper: assert property (result_write && $past(op_code[0], 3)
      |-> result_data[31:7] == 25'h0)
      else $error("flag vector upper bits set");
   chk_flag_op_quiet: assert property (result_write && $past(op_code[0], 3) && !other_update_valid
      |=> $stable(status_flags) || $rose(s_axi_bvalid))
      else $error("flag variant changed status flags");

   cover property (op_valid && guard_used && !guard[0]);
   cover property (other_update_valid && result_write);
   cover property (result_write && $past(op_code[0], 3));
endmodule // faa_checker

bind faa_float_abs_add_unit faa_checker faa_checker_i (
   .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
   .guard_used(guard_used), .guard(guard), .other_update_valid(other_update_valid),
   .other_update_flags(other_update_flags), .result_write(result_write),
   .result_data(result_data), .status_flags(status_flags), .s_axi_bvalid(s_axi_bvalid)
);

`default_nettype wire

// ---- tb/faa_regfile_model.sv ----
// Purpose: register file behind the unit's write-back port
// Assumes: 128 destinations
// Notes: a marker value shows a destination never written
`timescale 1ns/1ps
`default_nettype none

module faa_regfile_model (
   input wire logic clk,
   input wire logic result_write,
   input wire logic [6:0] result_dest,
   input wire logic [31:0] result_data
);
   logic [31:0] regs [0:127];

   initial begin
      for (int i = 0; i < 128; i++) begin
         regs[i] = 32'h5a5a5a5a;
      end
   end

   // only a strobed write may change a destination
   always @(posedge clk) begin
      if (result_write) begin
         regs[result_dest] <= result_data;
      end
   end
endmodule // faa_regfile_model

`default_nettype wire

// ---- tb/faa_float_abs_add_unit_test.sv ----
// Purpose: self-checking bench of the float magnitude/add unit
// Assumes: rows carry {round mode, op}, operands, result, flags
// Notes: flags are cleared over the bus before each row
`timescale 1ns/1ps
`default_nettype none
`include "faa_defines.vh"

module faa_float_abs_add_unit_test;
   logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, guard_used = 1'b0, other_update_valid = 1'b0;
   logic [1:0] op_code = 2'h0;
   logic [31:0] first_source = 32'h0, second_source = 32'h0, guard = 32'h0, s_axi_wdata = 32'h0;
   logic [6:0] op_dest = 7'h0, other_update_flags = 7'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire result_write, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [6:0] result_dest, status_flags;
   wire [31:0] result_data, s_axi_rdata;
   wire [1:0] round_mode, s_axi_bresp, s_axi_rresp;
   logic [31:0] rd;
   logic [1:0] rsp;
   integer mismatches = 0, n_checks = 0, cyc = 0;
   logic [107:0] rows [0:17];

   faa_float_abs_add_unit faa_float_abs_add_unit_i (
      .clk, .rst, .op_valid, .op_code, .first_source, .second_source, .guard_used, .guard,
      .op_dest, .other_update_valid, .other_update_flags, .result_write, .result_dest,
      .result_data, .status_flags, .round_mode, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );

   faa_regfile_model faa_regfile_model_i (.clk, .result_write, .result_dest, .result_data);

   always #5 clk = ~clk;

   // ==========
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // latency is fixed, so the wait after issue is a plain count
   task automatic issue(input logic [1:0] c, input logic [31:0] a, input logic [31:0] b,
         input logic [6:0] d, input logic gu, input logic [31:0] g, input int w);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= c;
      first_source <= a;
      second_source <= b;
      op_dest <= d;
      guard_used <= gu;
      guard <= g;
      @(posedge clk);
      op_valid <= 1'b0;
      repeat (w) @(posedge clk);
   endtask

   task print_verdict;
      if (mismatches == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches = mismatches + 1;
         print_verdict;
      end
   end

   // ==========
   // sequence
   initial begin
      rows = '{108'h0_40400000_00000000_40400000_00,
         108'h0_bf800000_00000000_3f800000_00,
         108'h0_00400000_00000000_00000000_20,
         108'h0_ffffffff_00000000_ffffffff_00,
         108'h0_ffbfffff_00000000_ffffffff_10,
         108'h1_00400000_00000000_00000020_00,
         108'h1_ffbfffff_00000000_00000010_00,
         108'h2_c0400000_3f800000_c0000000_00,
         108'h2_40400000_00800000_40400000_02,
         108'h2_40400000_00400000_40400000_20,
         108'h2_00c00000_80800000_00000000_46,
         108'h2_7f800000_ff800000_ffffffff_10,
         108'h2_7f7fffff_7f7fffff_7f800000_0a,
         108'h6_7f7fffff_7f7fffff_7f7fffff_0a,
         108'he_40400000_c0400000_80000000_00,
         108'ha_40400000_00800000_40400001_02,
         108'h3_00a00000_80800000_00000046_00,
         108'h3_7f800000_ff800000_00000010_00};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(status_flags), 32'h0);
      chk(32'(round_mode), 32'h0);
      chk(32'(irq), 32'h0);
      for (int i = 0; i < 18; i++) begin
         axw(`FAA_REG_STATUS_WORD, {22'h0, rows[i][107:106], 8'h00});
         chk(32'(round_mode), 32'(rows[i][107:106]));
         issue(rows[i][105:104], rows[i][103:72], rows[i][71:40], 7'(i), 1'b0, 32'h0, 3);
         chk(32'(result_write), 32'h1);
         chk(32'(result_dest), 32'(i));
         chk(result_data, rows[i][39:8]);
         @(posedge clk);
         chk(32'(status_flags), rows[i][104] ? 32'h0 : 32'(rows[i][6:0]));
      end
      // guard with high bits set: only bit 0 may count
      axw(`FAA_REG_STATUS_WORD, 32'h0);
      issue(`FAA_OP_ABS, 32'hffbfffff, 32'h0, 7'h64, 1'b1, 32'hfffffffe, 3);
      chk(32'(result_write), 32'h0);
      @(posedge clk);
      chk(32'(status_flags), 32'h0);
      chk(faa_regfile_model_i.regs[100], 32'h5a5a5a5a);
      issue(`FAA_OP_ABS, 32'hff7fffff, 32'h0, 7'h65, 1'b1, 32'h1, 4);
      chk(faa_regfile_model_i.regs[101], 32'h7f7fffff);
      issue(`FAA_OP_ABS, 32'hffbfffff, 32'h0, 7'h66, 1'b0, 32'h0, 2);
      other_update_valid <= 1'b1;
      other_update_flags <= 7'h01;
      @(posedge clk);
      other_update_valid <= 1'b0;
      @(posedge clk);
      chk(32'(status_flags), 32'h11);
      issue(`FAA_OP_ADD, 32'h40400000, 32'h3f800000, 7'h67, 1'b0, 32'h0, 4);
      chk(32'(status_flags), 32'h11);
      axw(`FAA_REG_IRQ_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      axw(`FAA_REG_IRQ_MASK, 32'h7f);
      chk(32'(irq), 32'h1);
      axw(`FAA_REG_IRQ_STATUS, 32'h7f);
      chk(32'(irq), 32'h0);
      axr(`FAA_REG_STATUS_WORD);
      chk(rd, 32'h11);
      axw(12'h00c, 32'h0);
      chk(32'(rsp), 32'h2);
      axr(12'h010);
      chk(rd, 32'h0);
      chk(32'(rsp), 32'h2);
      // reset while an op is in flight: its write-back and the flags must vanish
      axw(`FAA_REG_STATUS_WORD, 32'h00000311);
      issue(`FAA_OP_ABS, 32'hffbfffff, 32'h0, 7'h68, 1'b0, 32'h0, 0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(result_write), 32'h0);
      chk(32'(status_flags), 32'h0);
      chk(32'(round_mode), 32'h0);
      chk(32'(irq), 32'h0);
      @(posedge clk);
      chk(faa_regfile_model_i.regs[104], 32'h5a5a5a5a);
      print_verdict;
   end
endmodule // faa_float_abs_add_unit_test

`default_nettype wire
